// ==== src/rxev_map.svh ====
// Register offsets, field positions, reset values and event codes
`ifndef RXEV_MAP_SVH
`define RXEV_MAP_SVH
// ****************
// Register offsets
// ****************
`define RXEV_A_CTRL 8'h00
`define RXEV_A_ROUTE 8'h04
`define RXEV_A_STAT 8'h08
`define RXEV_A_LDROP 8'h0c
// Windows selected by adr[7:5]: queue access at 0x40, lengths at 0x60
`define RXEV_A_QWIN 3'h2
`define RXEV_A_LWIN 3'h3
// ****************
// Fields and reset values
// ****************
`define RXEV_CTRL_TS 0
`define RXEV_CTRL_ALWERR 1
`define RXEV_CTRL_BADFR 2
`define RXEV_CTRL_RST 3'h0
`define RXEV_R_ERR 0
`define RXEV_R_CNT 3
`define RXEV_R_TXC 6
`define RXEV_R_TXDMA 9
`define RXEV_R_RXDMA 12
`define RXEV_R_ABR 15
`define RXEV_R_POOL 18
`define RXEV_ROUTE_RST 21'h0_0000
`define RXEV_ST_DROP 0
`define RXEV_ST_BAD 1
`define RXEV_ST_FULL 8
`define RXEV_ST_EMPTY 16
`define RXEV_DEPTH 5'h10
// ****************
// Event codes
// ****************
`define RXEV_C_THR1 6'h1e
`define RXEV_C_THR2 6'h1f
`define RXEV_C_TS 6'h3f
`endif

// ==== src/rxev_pkg.sv ====
// Types shared by the receive event encoder files
package rxev_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STAMP = 2'b01,
        ST_POST = 2'b10
    } rxev_state_t;
    typedef enum logic [2:0] {
        CAT_BAD = 3'b000,
        CAT_NORMAL = 3'b001,
        CAT_ERROR = 3'b010,
        CAT_COUNT = 3'b011,
        CAT_TXC = 3'b100,
        CAT_TXDMA = 3'b101,
        CAT_RXDMA = 3'b110,
        CAT_ABR = 3'b111
    } rxev_cat_t;
endpackage

// ==== src/rxev_encode.sv ====
// Event word builder and queue router
`timescale 1ns/1ps
`default_nettype none
`include "rxev_map.svh"
module rxev_encode (
    // Held event
    input wire logic [5:0] code,
    input wire logic [25:0] info,
    input wire logic dir,
    input wire logic [2:0] chan_queue,
    // Settings
    input wire logic [2:0] ctrl,
    input wire logic [20:0] route,
    // Result
    output logic [31:0] word,
    output logic [2:0] qsel,
    output logic ok,
    output logic cancel
);
    function automatic rxev_pkg::rxev_cat_t cat_of(input logic [5:0] c);
        case (c) inside
            [6'h10:6'h12]: cat_of = rxev_pkg::CAT_ERROR;
            6'h13, 6'h16: cat_of = rxev_pkg::CAT_ERROR;
            6'h14, 6'h15: cat_of = rxev_pkg::CAT_NORMAL;
            [6'h18:6'h1b], 6'h3d: cat_of = rxev_pkg::CAT_COUNT;
            [6'h1e:6'h23]: cat_of = rxev_pkg::CAT_TXC;
            6'h24, 6'h26, 6'h28, 6'h29: cat_of = rxev_pkg::CAT_TXDMA;
            6'h25, 6'h27, 6'h3b: cat_of = rxev_pkg::CAT_RXDMA;
            [6'h2c:6'h2f]: cat_of = rxev_pkg::CAT_ABR;
            [6'h38:6'h3a], 6'h3c: cat_of = rxev_pkg::CAT_ERROR;
            6'h3e: cat_of = rxev_pkg::CAT_NORMAL;
            default: cat_of = rxev_pkg::CAT_BAD;
        endcase
    endfunction

    rxev_pkg::rxev_cat_t cat;
    always_comb begin
        cat = cat_of(code);
        ok = (cat != rxev_pkg::CAT_BAD);
        // Pointer in the upper bits, type in the low six
        word = {info, code};
        if (code == `RXEV_C_THR1 || code == `RXEV_C_THR2) begin
            word[6] = dir;
        end
        // Pool status rides its own route field
        case (cat)
            rxev_pkg::CAT_ERROR: begin
                if (ctrl[`RXEV_CTRL_ALWERR] || !ctrl[`RXEV_CTRL_BADFR]) begin
                    qsel = route[`RXEV_R_ERR +: 3];
                end else begin
                    qsel = chan_queue;
                end
            end
            rxev_pkg::CAT_COUNT: qsel = route[`RXEV_R_CNT +: 3];
            rxev_pkg::CAT_TXC: qsel = route[`RXEV_R_TXC +: 3];
            rxev_pkg::CAT_TXDMA: qsel = route[`RXEV_R_TXDMA +: 3];
            rxev_pkg::CAT_RXDMA: qsel = route[`RXEV_R_RXDMA +: 3];
            rxev_pkg::CAT_ABR: qsel = route[`RXEV_R_ABR +: 3];
            default: qsel = (code == 6'h3e) ? route[`RXEV_R_POOL +: 3] : chan_queue;
        endcase
        // Transmit side must abandon the buffer or descriptor
        cancel = (code == 6'h22) || (code == 6'h28) || (code == 6'h29);
    end
endmodule
`default_nettype wire

// ==== src/rxev_queue.sv ====
// Eight circular receive queues in one shared array
`timescale 1ns/1ps
`default_nettype none
`include "rxev_map.svh"
module rxev_queue (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Tail side
    input wire logic push,
    input wire logic [2:0] push_q,
    input wire logic [31:0] push_data,
    // Head side
    input wire logic pop,
    input wire logic [2:0] pop_q,
    output logic [31:0] pop_data,
    // Occupancy
    output logic [7:0] full,
    output logic [7:0] empty,
    output logic [39:0] lens
);
    logic [31:0] mem_q [0:127];
    logic [3:0] head_q [0:7];
    logic [3:0] tail_q [0:7];
    logic [4:0] cnt_q [0:7];
    logic do_push, do_pop;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            full[i] = (cnt_q[i] == `RXEV_DEPTH);
            empty[i] = (cnt_q[i] == 5'h00);
            lens[i*5 +: 5] = cnt_q[i];
        end
    end
    // A full queue takes nothing; caller records the drop
    assign do_push = push & ~full[push_q];
    assign do_pop = pop & ~empty[pop_q];
    assign pop_data = mem_q[{pop_q, head_q[pop_q]}];

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem_q[{push_q, tail_q[push_q]}] <= push_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                head_q[i] <= 4'h0;
                tail_q[i] <= 4'h0;
                cnt_q[i] <= 5'h00;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (do_push && push_q == i[2:0]) begin
                    tail_q[i] <= tail_q[i] + 4'h1;
                end
                if (do_pop && pop_q == i[2:0]) begin
                    head_q[i] <= head_q[i] + 4'h1;
                end
                cnt_q[i] <= cnt_q[i] + {4'h0, do_push && push_q == i[2:0]}
                    - {4'h0, do_pop && pop_q == i[2:0]};
            end
        end
    end
endmodule
`default_nettype wire

// ==== src/rxev_top.sv ====
// Receive event encoder: event intake, timestamping and queue access
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rxev_map.svh"
module rxev_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Event producers
    input wire logic ev_valid,
    output logic ev_ready,
    input wire logic [5:0] ev_code,
    input wire logic [25:0] ev_info,
    input wire logic ev_dir,
    input wire logic ev_has_buf,
    input wire logic [2:0] ev_chan_queue,
    input wire logic [25:0] ts_value,
    // Side effects
    output logic buf_free_valid,
    output logic [25:0] buf_free_ptr,
    output logic tx_cancel
);
    // ****************
    // Storage
    // ****************
    logic ack_q;
    logic [31:0] dat_q;
    logic [2:0] ctrl_q;
    logic [20:0] route_q;
    logic drop_q;
    logic bad_q;
    logic [31:0] ldrop_q;
    rxev_pkg::rxev_state_t state_q;
    logic ev_ready_q;
    logic [5:0] h_code_q;
    logic [25:0] h_info_q;
    logic [25:0] stamp_q;
    logic h_dir_q;
    logic h_buf_q;
    logic [2:0] h_lcq_q;
    logic bfv_q;
    logic [25:0] bfp_q;
    logic cancel_q;

    // ****************
    // Bus decode
    // ****************
    logic req, wr_ok, q_win, l_win, bus_push, bus_pop;
    assign req = cyc_i & stb_i & ~ack_q;
    // Registers are whole words; partial writes are ignored
    assign wr_ok = we_i & (sel_i == 4'hf);
    assign q_win = (adr_i[7:5] == `RXEV_A_QWIN);
    assign l_win = (adr_i[7:5] == `RXEV_A_LWIN);
    assign bus_push = req & wr_ok & q_win;
    assign bus_pop = req & ~we_i & q_win;

    // ****************
    // Encoder and queues
    // ****************
    logic [31:0] enc_word;
    logic [2:0] enc_q;
    logic enc_ok, enc_cancel;
    rxev_encode u_enc (
        .code(h_code_q),
        .info(h_info_q),
        .dir(h_dir_q),
        .chan_queue(h_lcq_q),
        .ctrl(ctrl_q),
        .route(route_q),
        .word(enc_word),
        .qsel(enc_q),
        .ok(enc_ok),
        .cancel(enc_cancel)
    );

    logic hw_step, hw_try, push_en;
    logic [2:0] push_q;
    logic [31:0] push_data, pop_data;
    logic [7:0] q_full, q_empty;
    logic [39:0] q_lens;
    // Software owns the tail port for a cycle; hardware waits
    assign hw_step = ~bus_push & (state_q != rxev_pkg::ST_IDLE);
    assign hw_try = hw_step & ((state_q == rxev_pkg::ST_STAMP) | enc_ok);
    assign push_en = bus_push | hw_try;
    assign push_q = bus_push ? adr_i[4:2] : enc_q;
    always_comb begin
        if (bus_push) begin
            push_data = dat_i;
        end else if (state_q == rxev_pkg::ST_STAMP) begin
            push_data = {stamp_q, `RXEV_C_TS};
        end else begin
            push_data = enc_word;
        end
    end
    logic dropping;
    assign dropping = push_en & q_full[push_q];

    rxev_queue u_q (
        .clock(clock),
        .rst(rst),
        .push(push_en),
        .push_q(push_q),
        .push_data(push_data),
        .pop(bus_pop),
        .pop_q(adr_i[4:2]),
        .pop_data(pop_data),
        .full(q_full),
        .empty(q_empty),
        .lens(q_lens)
    );

    // ****************
    // Event intake
    // ****************
    // One event in flight; the stamp costs one extra cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= rxev_pkg::ST_IDLE;
            ev_ready_q <= 1'b1;
        end else begin
            case (state_q)
                rxev_pkg::ST_IDLE: begin
                    if (ev_valid && ev_ready_q) begin
                        ev_ready_q <= 1'b0;
                        state_q <= ctrl_q[`RXEV_CTRL_TS] ? rxev_pkg::ST_STAMP
                            : rxev_pkg::ST_POST;
                    end
                end
                rxev_pkg::ST_STAMP: begin
                    if (hw_step) begin
                        state_q <= rxev_pkg::ST_POST;
                    end
                end
                rxev_pkg::ST_POST: begin
                    if (hw_step) begin
                        state_q <= rxev_pkg::ST_IDLE;
                        ev_ready_q <= 1'b1;
                    end
                end
                default: state_q <= rxev_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            h_code_q <= 6'h00;
            h_info_q <= 26'h000_0000;
            stamp_q <= 26'h000_0000;
            h_dir_q <= 1'b0;
            h_buf_q <= 1'b0;
            h_lcq_q <= 3'h0;
        end else if (ev_valid && ev_ready_q) begin
            h_code_q <= ev_code;
            h_info_q <= ev_info;
            stamp_q <= ts_value;
            h_dir_q <= ev_dir;
            h_buf_q <= ev_has_buf;
            h_lcq_q <= ev_chan_queue;
        end
    end

    // Dropped buffers go back to the pools; transmit cancels
    logic posting;
    assign posting = hw_step & (state_q == rxev_pkg::ST_POST);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bfv_q <= 1'b0;
            bfp_q <= 26'h000_0000;
            cancel_q <= 1'b0;
        end else begin
            bfv_q <= posting & enc_ok & dropping & h_buf_q;
            if (posting && enc_ok && dropping && h_buf_q) begin
                bfp_q <= h_info_q;
            end
            cancel_q <= posting & enc_ok & enc_cancel;
        end
    end

    // ****************
    // Registers
    // ****************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= `RXEV_CTRL_RST;
            route_q <= `RXEV_ROUTE_RST;
        end else if (req && wr_ok && adr_i == `RXEV_A_CTRL) begin
            ctrl_q <= dat_i[2:0];
        end else if (req && wr_ok && adr_i == `RXEV_A_ROUTE) begin
            route_q <= dat_i[20:0];
        end
    end

    // Sticky flags: a new drop beats a same-cycle clear
    logic clr_st;
    assign clr_st = req && wr_ok && adr_i == `RXEV_A_STAT;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drop_q <= 1'b0;
            bad_q <= 1'b0;
            ldrop_q <= 32'h0000_0000;
        end else begin
            if (dropping) begin
                drop_q <= 1'b1;
            end else if (clr_st && dat_i[`RXEV_ST_DROP]) begin
                drop_q <= 1'b0;
            end
            if (posting && !enc_ok) begin
                bad_q <= 1'b1;
            end else if (clr_st && dat_i[`RXEV_ST_BAD]) begin
                bad_q <= 1'b0;
            end
            // Frozen until software clears the drop flag
            if (dropping && !drop_q) begin
                ldrop_q <= push_data;
            end
        end
    end

    logic [31:0] rd_word, stat_word;
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`RXEV_ST_DROP] = drop_q;
        stat_word[`RXEV_ST_BAD] = bad_q;
        stat_word[`RXEV_ST_FULL +: 8] = q_full;
        stat_word[`RXEV_ST_EMPTY +: 8] = q_empty;
        if (q_win) begin
            // Empty queue reads as the null event
            rd_word = q_empty[adr_i[4:2]] ? 32'h0000_0000 : pop_data;
        end else if (l_win) begin
            rd_word = {27'h000_0000, q_lens[adr_i[4:2]*5 +: 5]};
        end else begin
            case (adr_i)
                `RXEV_A_CTRL: rd_word = {29'h0000_0000, ctrl_q};
                `RXEV_A_ROUTE: rd_word = {11'h000, route_q};
                `RXEV_A_STAT: rd_word = stat_word;
                `RXEV_A_LDROP: rd_word = ldrop_q;
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !we_i) begin
                dat_q <= rd_word;
            end
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign ev_ready = ev_ready_q;
    assign buf_free_valid = bfv_q;
    assign buf_free_ptr = bfp_q;
    assign tx_cancel = cancel_q;

    // ****************
    // Checks
    // ****************
    logic [2:0] pq_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pq_q <= 3'h0;
        end else begin
            pq_q <= push_q;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_code_low;
        posting && enc_ok |-> push_data[5:0] == h_code_q;
    endproperty
    a_code_low: assert property (p_code_low)
        else $error("Type code missing from low bits");
    property p_dir;
        posting && (h_code_q == `RXEV_C_THR1 || h_code_q == `RXEV_C_THR2)
            |-> push_data[6] == h_dir_q;
    endproperty
    a_dir: assert property (p_dir)
        else $error("Threshold direction bit wrong");
    property p_abr;
        posting && h_code_q inside {[6'h2c:6'h2f]} |-> push_q == route_q[`RXEV_R_ABR +: 3];
    endproperty
    a_abr: assert property (p_abr)
        else $error("ABR event not on ABR route");
    property p_stamp;
        hw_step && state_q == rxev_pkg::ST_STAMP
            |-> push_data[5:0] == `RXEV_C_TS ##1 state_q == rxev_pkg::ST_POST;
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("Timestamp not ahead of event");
    property p_free;
        posting && enc_ok && dropping && h_buf_q |=> bfv_q && bfp_q == $past(h_info_q);
    endproperty
    a_free: assert property (p_free)
        else $error("Dropped buffer not returned");
    property p_rsvd;
        hw_try |-> !(push_data[5:0] inside {6'h17, [6'h30:6'h37]});
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("Hardware posted reserved code");
    property p_deq;
        bus_pop && !q_empty[adr_i[4:2]] |=> ack_q && dat_q == $past(pop_data);
    endproperty
    a_deq: assert property (p_deq)
        else $error("Dequeue did not return head");
    property p_enq;
        bus_push && !q_full[push_q] |=> !q_empty[pq_q];
    endproperty
    a_enq: assert property (p_enq)
        else $error("Enqueue not appended");
    property p_cancel;
        posting && h_code_q == 6'h22 |=> tx_cancel;
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("Bad buffer not cancelled");
    property p_info;
        posting && h_code_q inside {[6'h10:6'h16]} |-> push_data[31:6] == h_info_q;
    endproperty
    a_info: assert property (p_info)
        else $error("Channel pointer not carried");

    c_stamp: cover property (hw_step && state_q == rxev_pkg::ST_STAMP);
    c_drop: cover property (posting && dropping && h_buf_q);
    c_deq: cover property (bus_pop && !q_empty[adr_i[4:2]]);
endmodule
`default_nettype wire

// ==== tb/test_rxev_top.sv ====
// Self-checking bench for the receive event encoder
`timescale 1ns/1ps
`default_nettype none
module test_rxev_top;
    // ****************
    // Signals
    // ****************
    logic clock;
    logic rst;
    logic cyc_i, stb_i, we_i;
    logic [7:0] adr_i;
    logic [31:0] dat_i;
    logic [3:0] sel_i;
    logic [31:0] dat_o;
    logic ack_o;
    logic ev_valid, ev_ready, ev_dir, ev_has_buf;
    logic [5:0] ev_code;
    logic [25:0] ev_info, ts_value, buf_free_ptr;
    logic [2:0] ev_chan_queue;
    logic buf_free_valid, tx_cancel;
    int err_total = 0;
    int compares = 0;

    rxev_top dut_u (
        .clock(clock), .rst(rst),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
        .ev_valid(ev_valid), .ev_ready(ev_ready), .ev_code(ev_code), .ev_info(ev_info),
        .ev_dir(ev_dir), .ev_has_buf(ev_has_buf), .ev_chan_queue(ev_chan_queue),
        .ts_value(ts_value), .buf_free_valid(buf_free_valid), .buf_free_ptr(buf_free_ptr),
        .tx_cancel(tx_cancel)
    );

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic give_up();
        err_total++;
        final_report();
    endtask

    // Classic cycle: hold until ack is seen at an edge, then release
    task automatic wb(input logic is_wr, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= is_wr;
        sel_i <= 4'hf;
        adr_i <= adr;
        dat_i <= wd;
        do begin
            @(posedge clock);
            #1;
            n++;
            if (n > 50) give_up();
        end while (ack_o !== 1'b1);
        @(posedge clock);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] unused;
        wb(1'b1, adr, wd, unused);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] got;
        wb(1'b0, adr, 32'h0000_0000, got);
        chk(what, exp, got);
    endtask

    // Offers one event and counts side-effect pulses until ready returns
    task automatic post(input logic [5:0] c, input logic [25:0] inf, input logic d,
                        input logic hb, input logic [2:0] lcq, output int ncan,
                        output int nfree);
        int n;
        n = 0;
        ncan = 0;
        nfree = 0;
        @(posedge clock);
        ev_valid <= 1'b1;
        ev_code <= c;
        ev_info <= inf;
        ev_dir <= d;
        ev_has_buf <= hb;
        ev_chan_queue <= lcq;
        #1;
        while (ev_ready !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 50) give_up();
        end
        @(posedge clock);
        ev_valid <= 1'b0;
        do begin
            @(posedge clock);
            #1;
            n++;
            if (tx_cancel === 1'b1) ncan++;
            if (buf_free_valid === 1'b1) nfree++;
            if (n > 50) give_up();
        end while (ev_ready !== 1'b1);
    endtask

    function automatic logic is_valid(input logic [5:0] c);
        return (c >= 6'h10 && c <= 6'h16) || (c >= 6'h18 && c <= 6'h1b)
            || (c >= 6'h1e && c <= 6'h29) || (c >= 6'h2c && c <= 6'h2f)
            || (c >= 6'h38 && c <= 6'h3e);
    endfunction

    // Queue per code with ROUTE fields err..pool = 1..7 and channel queue 0
    function automatic logic [2:0] exp_q(input logic [5:0] c);
        case (c)
            6'h14, 6'h15: return 3'h0;
            6'h18, 6'h19, 6'h1a, 6'h1b, 6'h3d: return 3'h2;
            6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23: return 3'h3;
            6'h24, 6'h26, 6'h28, 6'h29: return 3'h4;
            6'h25, 6'h27, 6'h3b: return 3'h5;
            6'h2c, 6'h2d, 6'h2e, 6'h2f: return 3'h6;
            6'h3e: return 3'h7;
            default: return 3'h1;
        endcase
    endfunction

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        rd_chk("status", 8'h08, 32'h00ff_0000);
        rd_chk("control", 8'h00, 32'h0000_0000);
        rd_chk("empty dequeue", 8'h40, 32'h0000_0000);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
    endtask

    task automatic t_codes();
        logic [5:0] code;
        logic [25:0] inf;
        logic [31:0] w;
        int ncan, nfree;
        wr(8'h04, 32'h001f_58d1);
        rd_chk("route", 8'h04, 32'h001f_58d1);
        for (int c = 16; c < 63; c++) begin
            code = 6'(c);
            inf = 26'h2a5_a5a5 ^ {20'h0_0000, code};
            w = {inf, code};
            if (code == 6'h1e || code == 6'h1f) w[6] = ~inf[0];
            post(code, inf, ~inf[0], 1'b0, 3'h0, ncan, nfree);
            if (is_valid(code)) begin
                rd_chk("event word", 8'h40 | {3'h0, exp_q(code), 2'h0}, w);
                chk("cancel", {31'h0, code == 6'h22 || code >= 6'h28 && code <= 6'h29},
                    32'(ncan));
                rd_chk("status after post", 8'h08, 32'h00ff_0000);
            end else begin
                rd_chk("refused", 8'h08, 32'h00ff_0002);
                wr(8'h08, 32'h0000_0002);
            end
            chk("no free", 32'h0000_0000, 32'(nfree));
        end
    endtask

    task automatic t_stamp();
        int ncan, nfree;
        wr(8'h00, 32'h0000_0001);
        post(6'h20, 26'h012_3456, 1'b0, 1'b0, 3'h0, ncan, nfree);
        rd_chk("stamp", 8'h4c, {ts_value, 6'h3f});
        rd_chk("stamped event", 8'h4c, {26'h012_3456, 6'h20});
        wr(8'h00, 32'h0000_0000);
    endtask

    task automatic t_full();
        logic [31:0] got;
        int ncan, nfree;
        for (int i = 0; i < 16; i++) begin
            wr(8'h44, 32'h0abc_0030 + 32'(i * 64 + i % 8));
        end
        rd_chk("length", 8'h64, 32'h0000_0010);
        rd_chk("full status", 8'h08, 32'h00fd_0200);
        post(6'h10, 26'h123_4567, 1'b0, 1'b1, 3'h0, ncan, nfree);
        chk("free pulses", 32'h0000_0001, 32'(nfree));
        chk("free ptr", {6'h00, 26'h123_4567}, {6'h00, buf_free_ptr});
        rd_chk("dropped", 8'h08, 32'h00fd_0201);
        rd_chk("last dropped", 8'h0c, {26'h123_4567, 6'h10});
        wr(8'h08, 32'h0000_0001);
        for (int i = 0; i < 16; i++) begin
            wb(1'b0, 8'h44, 32'h0000_0000, got);
            chk("dequeue order", 32'h0abc_0030 + 32'(i * 64 + i % 8), got);
            chk("type field", 32'(6'h30 + i % 8), got & 32'h0000_003f);
        end
        rd_chk("drained", 8'h08, 32'h00ff_0000);
    endtask

    task automatic t_badfr();
        int ncan, nfree;
        wr(8'h00, 32'h0000_0004);
        post(6'h13, 26'h000_0abc, 1'b0, 1'b0, 3'h2, ncan, nfree);
        rd_chk("bad frame route", 8'h48, {26'h000_0abc, 6'h13});
        wr(8'h00, 32'h0000_0006);
        post(6'h13, 26'h000_0abd, 1'b0, 1'b0, 3'h2, ncan, nfree);
        rd_chk("error route", 8'h44, {26'h000_0abd, 6'h13});
        post(6'h14, 26'h000_0abe, 1'b0, 1'b0, 3'h5, ncan, nfree);
        rd_chk("channel route", 8'h54, {26'h000_0abe, 6'h14});
        wr(8'h00, 32'h0000_0000);
    endtask

    // ****************
    // Clock and sequence
    // ****************
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        rst = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        dat_i = 32'h0000_0000;
        sel_i = 4'hf;
        ev_valid = 1'b0;
        ev_code = 6'h00;
        ev_info = 26'h000_0000;
        ev_dir = 1'b0;
        ev_has_buf = 1'b0;
        ev_chan_queue = 3'h0;
        ts_value = 26'h2ab_cdef;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_codes();
        t_stamp();
        t_full();
        t_badfr();
        final_report();
    end
endmodule
`default_nettype wire
